// ===== logic/arc_pkg.sv
// package: constants and types for the analog reference conditioner
package arc_pkg;
  // sample word: signed, full scale +/-10000 counts (1 mV per count)
  localparam int          SMP_W        = 16;
  localparam int          NCH          = 3;
  localparam int          CH_V1        = 0;
  localparam int          CH_CL        = 1;
  localparam int          CH_V2        = 2;
  localparam int          FULL_SCALE   = 10000;
  // offset in 0.1 % units, -50..+50
  localparam int          OFS_W        = 8;
  localparam int          OFS_MIN      = -50;
  localparam int          OFS_MAX      = 50;
  localparam int          OFS_DIV      = 1000;
  // gain and base points in 0.01 % units, 0..10000 (bias value -10000..10000)
  localparam int          PCT_W        = 16;
  localparam int          PCT_FULL     = 10000;
  // filter time in 0.01 s units, 0..500
  localparam int          FT_W         = 10;
  localparam int          FT_MAX       = 500;
  // one filter time unit (0.01 s) in microseconds
  localparam int          FT_UNIT_US   = 10000;
  // filter sample tick: 1 ms at 250 MHz
  localparam int          CLK_MHZ      = 250;
  localparam int          TICK_US      = 1000;
  localparam int          TICK_CYC     = CLK_MHZ * TICK_US;
  localparam int          TICK_W       = 18;
  // filter accumulator fraction bits
  localparam int          FRAC_W       = 16;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [1:0]  POL_BIPOLAR  = 2'h0;
  localparam logic        POL_UNIPOLAR = 1'h1;
  typedef enum logic [1:0] {
    ARC_IDLE = 2'b00,
    ARC_CALC = 2'b01,
    ARC_PUSH = 2'b11
  } arc_state_e;
endpackage

// ===== logic/arc_fifo.sv
// fifo: parameterised synchronous buffer with valid/ready on both sides
`timescale 1ns/1ps
module arc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;
  assign in_ready_o  = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_r != rd_r;
  assign push        = ce_i && in_valid_i && in_ready_o;
  assign pop         = ce_i && out_valid_o && out_ready_i;
  assign out_data_o  = mem_r[rd_r[AW-1:0]];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

// ===== logic/arc_conditioner.sv
// top: three-channel analog reference conditioner with output fifo
`timescale 1ns/1ps
// Operation
// R1: three channels: two voltage inputs and one 4 to 20 mA current loop.
// R2: each channel adds offset of -5.0 to +5.0 percent full scale.
// R3: first-order filter, time constant 0.00 to 5.00 s; larger means slower.
// R4: polarity 0 passes the full signed -10 to +10 V range.
// R5: polarity 1 uses 0 to +10 V; negative input becomes zero.
// R6: polarity setting exists for voltage channels only, not current loop.
// R7: pid command bias -100.00 to 100.00 percent, linear mapping with gain.
// R8: pid bias base point 0.00 to 100.00 percent of input span.
// R9: one gain and gain base per channel, shared by frequency and pid paths.
// R10: order is clamp, offset, gain/bias mapping, then per-tick low-pass filter.
// R11: zero filter time passes each conditioned sample unchanged.
module arc_conditioner
  import arc_pkg::*;
#(
  parameter int TICK_CYCLES = arc_pkg::TICK_CYC
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            ce_i,
  input  wire logic signed [arc_pkg::SMP_W-1:0] first_voltage_input_i,
  input  wire logic signed [arc_pkg::SMP_W-1:0] current_loop_input_i,
  input  wire logic signed [arc_pkg::SMP_W-1:0] second_voltage_input_i,
  input  wire logic signed [arc_pkg::OFS_W-1:0] first_voltage_offset_i,
  input  wire logic signed [arc_pkg::OFS_W-1:0] current_loop_offset_i,
  input  wire logic signed [arc_pkg::OFS_W-1:0] second_voltage_offset_i,
  input  wire logic        [arc_pkg::PCT_W-1:0] first_voltage_gain_i,
  input  wire logic        [arc_pkg::PCT_W-1:0] current_loop_gain_i,
  input  wire logic        [arc_pkg::PCT_W-1:0] second_voltage_gain_i,
  input  wire logic        [arc_pkg::PCT_W-1:0] first_voltage_gain_base_i,
  input  wire logic        [arc_pkg::PCT_W-1:0] current_loop_gain_base_i,
  input  wire logic        [arc_pkg::PCT_W-1:0] second_voltage_gain_base_i,
  input  wire logic        [arc_pkg::FT_W-1:0]  first_voltage_filter_time_i,
  input  wire logic        [arc_pkg::FT_W-1:0]  current_loop_filter_time_i,
  input  wire logic        [arc_pkg::FT_W-1:0]  second_voltage_filter_time_i,
  input  wire logic                            first_voltage_polarity_sel_i,
  input  wire logic                            second_voltage_polarity_sel_i,
  input  wire logic signed [arc_pkg::PCT_W-1:0] pid_cmd_bias_value_i,
  input  wire logic        [arc_pkg::PCT_W-1:0] pid_cmd_bias_base_i,
  output logic signed [arc_pkg::SMP_W-1:0]      cmd_first_voltage_o,
  output logic signed [arc_pkg::SMP_W-1:0]      cmd_current_loop_o,
  output logic signed [arc_pkg::SMP_W-1:0]      cmd_second_voltage_o,
  output logic                                 cmd_valid_o,
  input  wire logic                            cmd_ready_i,
  output logic                                 overrun_o
);
  // a tick period must cover idle, three channel steps and the push
  if (TICK_CYCLES < 5 || TICK_CYCLES >= (1 << TICK_W)) begin
    $error("tick count out of range");
  end

  // ************************************************************
  // reset and input synchronisers
  // ************************************************************
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // converter words arrive from outside the clock domain
  logic signed [SMP_W-1:0] raw_s1_r [NCH];
  logic signed [SMP_W-1:0] raw_r    [NCH];
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        raw_s1_r[i] <= '0;
        raw_r[i]    <= '0;
      end
    end else if (ce_i) begin
      raw_s1_r[CH_V1] <= first_voltage_input_i;
      raw_s1_r[CH_CL] <= current_loop_input_i;     // R1
      raw_s1_r[CH_V2] <= second_voltage_input_i;
      for (int i = 0; i < NCH; i++) begin
        raw_r[i] <= raw_s1_r[i];
      end
    end
  end

  // per-channel settings gathered into arrays
  logic signed [OFS_W-1:0] ofs   [NCH];
  logic        [PCT_W-1:0] gain  [NCH];
  logic        [PCT_W-1:0] gbase [NCH];
  logic        [FT_W-1:0]  ftime [NCH];
  logic                    unipol[NCH];
  always_comb begin
    ofs[CH_V1]    = first_voltage_offset_i;
    ofs[CH_CL]    = current_loop_offset_i;
    ofs[CH_V2]    = second_voltage_offset_i;
    gain[CH_V1]   = first_voltage_gain_i;     // R9
    gain[CH_CL]   = current_loop_gain_i;
    gain[CH_V2]   = second_voltage_gain_i;
    gbase[CH_V1]  = first_voltage_gain_base_i;
    gbase[CH_CL]  = current_loop_gain_base_i;
    gbase[CH_V2]  = second_voltage_gain_base_i;
    ftime[CH_V1]  = first_voltage_filter_time_i;
    ftime[CH_CL]  = current_loop_filter_time_i;
    ftime[CH_V2]  = second_voltage_filter_time_i;
    unipol[CH_V1] = first_voltage_polarity_sel_i;
    unipol[CH_CL] = 1'b0;                     // R6
    unipol[CH_V2] = second_voltage_polarity_sel_i;
  end

  // ************************************************************
  // sample tick and sequencer
  // ************************************************************
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick;
  assign tick = tick_cnt_r == TICK_W'(TICK_CYCLES - 1);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (ce_i) begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  arc_state_e state_r;
  logic [1:0] ch_r;
  logic       fifo_in_ready;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ARC_IDLE;
      ch_r    <= '0;
    end else if (ce_i) begin
      case (state_r)
        ARC_IDLE: begin
          if (tick) begin
            state_r <= ARC_CALC;
            ch_r    <= '0;
          end
        end
        ARC_CALC: begin
          // keep ch_r a valid index so the settings mux never reads past the arrays
          if (ch_r == 2'(NCH - 1)) begin
            state_r <= ARC_PUSH;
            ch_r    <= '0;
          end else begin
            ch_r <= ch_r + 1'b1;
          end
        end
        ARC_PUSH: state_r <= ARC_IDLE;
        default:  state_r <= ARC_IDLE;
      endcase
    end
  end

  // ************************************************************
  // clamp, offset, gain/bias mapping for the channel in turn
  // ************************************************************
  logic signed [31:0] x_clamp;
  logic signed [31:0] x_ofs;
  logic signed [31:0] x_map;
  logic signed [31:0] span;
  logic signed [31:0] bias_at;
  logic signed [31:0] bias_cmd;
  logic signed [SMP_W-1:0] x_sat;
  always_comb begin
    x_clamp = 32'(raw_r[ch_r]);
    if (unipol[ch_r] && x_clamp < 0) begin
      x_clamp = '0;                                             // R5
    end                                                         // R4
    x_ofs = x_clamp + (32'(ofs[ch_r]) * FULL_SCALE) / OFS_DIV;  // R2
    // gain/base point: output reaches gain percent at base percent of span
    span = (gbase[ch_r] == '0) ? 32'(PCT_FULL) : 32'(gbase[ch_r]);
    // gain kept signed so negative inputs scale correctly
    x_map = (x_ofs * $signed(32'(gain[ch_r]))) / span;
    // pid bias: output equals bias value at bias base point of input span
    bias_at  = 32'(pid_cmd_bias_base_i) * FULL_SCALE / PCT_FULL;  // R8
    bias_cmd = 32'(pid_cmd_bias_value_i) * FULL_SCALE / PCT_FULL; // R7
    x_map = x_map + bias_cmd - (bias_at * $signed(32'(gain[ch_r]))) / span;
    if (x_map > FULL_SCALE) begin
      x_sat = SMP_W'(FULL_SCALE);
    end else if (x_map < -FULL_SCALE) begin
      x_sat = SMP_W'(-FULL_SCALE);
    end else begin
      x_sat = SMP_W'(x_map);
    end
  end

  // ************************************************************
  // first-order low-pass: y += (x - y) * dt / (tau + dt)
  // ************************************************************
  // trade-off: divider per channel step instead of a lookup of coefficients
  logic signed [SMP_W+FRAC_W-1:0] acc_r [NCH];
  logic signed [47:0]             err;
  logic signed [47:0]             step;
  logic        [31:0]             denom;
  always_comb begin
    // dt / (tau + dt) in microseconds; limitation: assumes the tick is TICK_US long
    denom = 32'(ftime[ch_r]) * 32'(FT_UNIT_US) + 32'(TICK_US);  // R3
    err   = 48'($signed({x_sat, {FRAC_W{1'b0}}})) - 48'(acc_r[ch_r]);
    step  = (err * 48'(TICK_US)) / $signed({16'h0, denom});
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        acc_r[i] <= '0;
      end
    end else if (ce_i && state_r == ARC_CALC) begin             // R10
      if (ftime[ch_r] == '0) begin
        acc_r[ch_r] <= {x_sat, {FRAC_W{1'b0}}};                 // R11
      end else begin
        acc_r[ch_r] <= acc_r[ch_r] + (SMP_W+FRAC_W)'(step);     // R3
      end
    end
  end

  // ************************************************************
  // output fifo; a full fifo drops the tick and flags overrun
  // ************************************************************
  logic [NCH*SMP_W-1:0] fifo_out;
  logic                 push_v;
  assign push_v = state_r == ARC_PUSH;
  arc_fifo #(
    .WIDTH (NCH * SMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .ce_i        (ce_i),
    .in_data_i   ({acc_r[CH_V2][SMP_W+FRAC_W-1:FRAC_W],
                   acc_r[CH_CL][SMP_W+FRAC_W-1:FRAC_W],
                   acc_r[CH_V1][SMP_W+FRAC_W-1:FRAC_W]}),
    .in_valid_i  (push_v),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (cmd_valid_o),
    .out_ready_i (cmd_ready_i)
  );
  assign cmd_first_voltage_o  = fifo_out[SMP_W-1:0];
  assign cmd_current_loop_o   = fifo_out[2*SMP_W-1:SMP_W];
  assign cmd_second_voltage_o = fifo_out[3*SMP_W-1:2*SMP_W];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      overrun_o <= 1'b0;
    end else if (ce_i && push_v && !fifo_in_ready) begin
      overrun_o <= 1'b1;
    end
  end
endmodule

// ===== tb/arc_chk.sv
// checker: port-level assertions for the analog reference conditioner
`timescale 1ns/1ps
module arc_chk
  import arc_pkg::*;
#(
  parameter int TICK_CYCLES = 16
) (
  input wire logic                     clk_i,
  input wire logic                     rst_n_i,
  input wire logic                     ce_i,
  input wire logic signed [SMP_W-1:0]  cmd_first_voltage_o,
  input wire logic signed [SMP_W-1:0]  cmd_current_loop_o,
  input wire logic signed [SMP_W-1:0]  cmd_second_voltage_o,
  input wire logic                     cmd_valid_o,
  input wire logic                     cmd_ready_i,
  input wire logic                     overrun_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // stream hold and range
  // ****************************************
  AST_HOLD_V1: assert property (
    cmd_valid_o && !cmd_ready_i && ce_i |=> cmd_valid_o && $stable(cmd_first_voltage_o))
    else $error("first voltage word moved while stalled");
  AST_HOLD_CL: assert property (
    cmd_valid_o && !cmd_ready_i && ce_i |=> $stable(cmd_current_loop_o))
    else $error("current loop word moved while stalled");
  AST_HOLD_V2: assert property (
    cmd_valid_o && !cmd_ready_i && ce_i |=> $stable(cmd_second_voltage_o))
    else $error("second voltage word moved while stalled");
  AST_RANGE_V1: assert property (
    cmd_valid_o |-> cmd_first_voltage_o <= FULL_SCALE && cmd_first_voltage_o >= -FULL_SCALE)
    else $error("first voltage word out of range");
  AST_RANGE_CL: assert property (
    cmd_valid_o |-> cmd_current_loop_o <= FULL_SCALE && cmd_current_loop_o >= -FULL_SCALE)
    else $error("current loop word out of range");
  AST_RANGE_V2: assert property (
    cmd_valid_o |-> cmd_second_voltage_o <= FULL_SCALE && cmd_second_voltage_o >= -FULL_SCALE)
    else $error("second voltage word out of range");
  // ****************************************
  // overrun and start-up
  // ****************************************
  AST_OVR_STICKY: assert property (
    overrun_o |=> overrun_o) else $error("overrun flag cleared without reset");
  AST_OVR_CAUSE: assert property (
    $rose(overrun_o) |-> !$past(cmd_ready_i, 2)) else $error("overrun while draining");
  AST_RESET_QUIET: assert property (
    $rose(rst_n_i) |-> (!cmd_valid_o && !overrun_o) [*8])
    else $error("output active right after reset");
  COV_POP: cover property (cmd_valid_o && cmd_ready_i);
  COV_STALL: cover property (cmd_valid_o && !cmd_ready_i);
  COV_OVR: cover property ($rose(overrun_o));
endmodule

// ===== tb/arc_src.sv
// partner: analog source model delivering converter words
`timescale 1ns/1ps
module arc_src
  import arc_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic signed [SMP_W-1:0] lvl_v1_i,
  input  wire logic signed [SMP_W-1:0] lvl_cl_i,
  input  wire logic signed [SMP_W-1:0] lvl_v2_i,
  output logic signed [SMP_W-1:0]      word_v1_o,
  output logic signed [SMP_W-1:0]      word_cl_o,
  output logic signed [SMP_W-1:0]      word_v2_o
);
  // one conversion per clock on all three channels
  always_ff @(posedge clk_i) begin
    word_v1_o <= lvl_v1_i;
    word_cl_o <= lvl_cl_i;
    word_v2_o <= lvl_v2_i;
  end
endmodule

// ===== tb/arc_conditioner_tb.sv
// testbench: table-driven checks of the analog reference conditioner
`timescale 1ns/1ps
module arc_conditioner_tb;
  import arc_pkg::*;
  localparam int TICK_CYCLES = 16;
  typedef logic signed [SMP_W-1:0] arc_w_t;
  typedef struct {arc_w_t x; logic signed [OFS_W-1:0] o; logic p;
    logic [PCT_W-1:0] g; arc_w_t bv; logic [PCT_W-1:0] bb; arc_w_t e1, ec, e2;} arc_row_s;
  logic clk_i = 0, rst_n_i = 0, rdy = 1, pol = 0, ce = 1, ovr, vld;
  arc_w_t lv = 0, w1, wc, w2, c1, cc, c2, bv = 0;
  logic signed [OFS_W-1:0] ofs = 0;
  logic [PCT_W-1:0] gn = 16'h2710, bb = 0;
  logic [FT_W-1:0] ft = 0;
  int num_errors = 0, n_checks = 0, cyc = 0, k;
  arc_row_s rows [10] = '{
    '{1000, 0, 0, 10000, 0, 0, 1000, 1000, 1000},
    '{-4000, 0, 0, 10000, 0, 0, -4000, -4000, -4000},
    '{-4000, 0, 1, 10000, 0, 0, 0, -4000, 0},
    '{5000, 50, 0, 10000, 0, 0, 5500, 5500, 5500},
    '{5000, -50, 0, 10000, 0, 0, 4500, 4500, 4500},
    '{-3000, 20, 1, 10000, 0, 0, 200, -2800, 200},
    '{9800, 50, 0, 10000, 0, 0, 10000, 10000, 10000},
    '{4000, 0, 0, 5000, 0, 0, 2000, 2000, 2000},
    '{1000, 0, 0, 10000, -1500, 0, -500, -500, -500},
    '{3000, 0, 0, 10000, 0, 2000, 1000, 1000, 1000}};
  initial forever #2 clk_i = ~clk_i;
  arc_src src_u (.clk_i(clk_i), .lvl_v1_i(lv), .lvl_cl_i(lv), .lvl_v2_i(lv),
    .word_v1_o(w1), .word_cl_o(wc), .word_v2_o(w2));
  arc_conditioner #(.TICK_CYCLES(TICK_CYCLES)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce), .first_voltage_input_i(w1), .current_loop_input_i(wc),
    .second_voltage_input_i(w2), .first_voltage_offset_i(ofs), .current_loop_offset_i(ofs),
    .second_voltage_offset_i(ofs), .first_voltage_gain_i(gn), .current_loop_gain_i(gn),
    .second_voltage_gain_i(gn), .first_voltage_gain_base_i(16'h2710),
    .current_loop_gain_base_i(16'h2710), .second_voltage_gain_base_i(16'h2710),
    .first_voltage_filter_time_i(ft), .current_loop_filter_time_i(ft),
    .second_voltage_filter_time_i(ft), .first_voltage_polarity_sel_i(pol),
    .second_voltage_polarity_sel_i(pol), .pid_cmd_bias_value_i(bv), .pid_cmd_bias_base_i(bb),
    .cmd_first_voltage_o(c1), .cmd_current_loop_o(cc), .cmd_second_voltage_o(c2),
    .cmd_valid_o(vld), .cmd_ready_i(rdy), .overrun_o(ovr));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [SMP_W-1:0] seen, input logic [SMP_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for one popped word; ready is held high by the caller
  task automatic get_word();
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge clk_i);
      if (vld === 1'b1) break;
    end
    if (i == 100) chk(16'h0, 16'h1);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1;
    chk(vld, 1'b0);
    for (k = 0; k < 10; k++) begin
      lv <= rows[k].x;
      ofs <= rows[k].o;
      pol <= rows[k].p;
      gn <= rows[k].g;
      bv <= rows[k].bv;
      bb <= rows[k].bb;
      repeat (3) get_word();
      chk(c1, rows[k].e1);
      chk(cc, rows[k].ec);
      chk(c2, rows[k].e2);
    end
    // first-order step: tau 0.01 s over a 1 ms tick closes 1/11 of the gap per tick,
    // so after n ticks the word is floor(4000 * (1 - (10/11)^n))
    lv <= 0;
    gn <= 16'h2710;
    bv <= 0;
    bb <= 0;
    ofs <= 0;
    pol <= 0;
    repeat (3) get_word();
    chk(c1, 16'h0);
    ft <= 1;
    lv <= 4000;
    get_word();
    chk(c1, 16'sd363);
    get_word();
    chk(c1, 16'sd694);
    get_word();
    chk(cc, 16'sd994);
    // clock enable low: no tick completes, so no word appears
    ce <= 0;
    repeat (3 * TICK_CYCLES) @(posedge clk_i);
    chk(vld, 1'b0);
    ce <= 1;
    // stall past the buffer depth, then drain
    rdy <= 0;
    repeat (12 * TICK_CYCLES) @(posedge clk_i);
    chk(ovr, 1'b1);
    rdy <= 1;
    for (k = 0; k < FIFO_DEPTH; k++) begin
      @(posedge clk_i);
      chk(vld, 1'b1);
    end
    // mid-run reset: only a reset clears the sticky overrun; the reset also empties the buffer
    rst_n_i <= 0;
    repeat (2) @(posedge clk_i);
    chk(ovr, 1'b0);
    chk(vld, 1'b0);
    rst_n_i <= 1;
    repeat (12) @(posedge clk_i);
    chk(vld, 1'b0);
    end_sim();
  end
endmodule
bind arc_conditioner arc_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .ce_i(ce_i), .cmd_first_voltage_o(cmd_first_voltage_o),
  .cmd_current_loop_o(cmd_current_loop_o), .cmd_second_voltage_o(cmd_second_voltage_o),
  .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i), .overrun_o(overrun_o));
